/* File: bench/fb_source.sv */
`timescale 1ns/1ps

module fb_source (
  // clock
  input  wire logic       clk_in,
  // wanted levels trig, set, clear
  input  wire logic [2:0] want_in,
  // outputs toward the relay
  output logic            trig_out,
  output logic            set_out,
  output logic            clear_out
);
  // other blocks move off the sampling edge, so the relay never races them
  always @(negedge clk_in) begin
    {trig_out, set_out, clear_out} <= want_in;
  end
endmodule // fb_source

/* File: bench/toggle_relay_set_reset_tb_top.sv */
`timescale 1ns/1ps

module toggle_relay_set_reset_tb_top;
  import toggle_relay_pkg::*;
  logic           clk = 1'h0;
  logic           rst = 1'h1;
  logic           eval = 1'h0;
  logic           restart = 1'h0;
  logic           restore = 1'h0;
  priority_mode_t prio = clear_priority_mode;
  retain_mode_t   retain = retain_off;
  logic [2:0]     want = 3'h0;
  logic           trig, set, clr, relay, saved, tog;
  int             err_count = 0;
  int             num_checks = 0;

  always #20 clk = ~clk;

  fb_source src (.clk_in(clk), .want_in(want), .trig_out(trig),
    .set_out(set), .clear_out(clr));

  toggle_relay_set_reset uut (.sys_clk_in(clk), .reset_in(rst),
    .eval_in(eval), .restart_in(restart), .restore_value_in(restore),
    .priority_mode_in(prio), .retain_mode_in(retain), .trig_in(trig),
    .set_in(set), .clear_in(clr), .relay_out(relay),
    .saved_value_out(saved), .toggled_out(tog));

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic q, input logic t);
    num_checks++;
    if (relay !== q || saved !== q || tog !== t) begin
      err_count++;
      $display("wrong value at %0t: got %b%b%b exp %b%b", $time, relay,
        saved, tog, q, t);
    end
  endtask

  task automatic ev(input logic [2:0] w, input logic q, input logic t);
    want = w;
    @(negedge clk);
    @(posedge clk);
    #1;
    check(q, t);
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic test_toggle;
    ev(3'h0, 1'h0, 1'h0);
    ev(3'h4, 1'h1, 1'h1);
    ev(3'h4, 1'h1, 1'h0);
    ev(3'h0, 1'h1, 1'h0);
    ev(3'h4, 1'h0, 1'h1);
    $display("test toggle done");
  endtask

  task automatic test_forced;
    ev(3'h0, 1'h0, 1'h0);
    ev(3'h6, 1'h1, 1'h0);
    ev(3'h2, 1'h1, 1'h0);
    ev(3'h1, 1'h0, 1'h0);
    ev(3'h5, 1'h0, 1'h0);
    ev(3'h5, 1'h0, 1'h0);
    $display("test forced done");
  endtask

  task automatic test_both;
    for (int m = 0; m < 2; m++) begin
      @(negedge clk);
      prio = priority_mode_t'(m);
      @(posedge clk);
      #1;
      ev(3'h3, 1'(m), 1'h0);
      ev(3'h7, 1'(m), 1'h0);
      ev(3'h0, 1'(m), 1'h0);
    end
    $display("test both done");
  endtask

  // restart while set is held: restart wins, set acts again next cycle
  task automatic restart_case(input logic r, input logic v);
    ev(3'h2, 1'h1, 1'h0);
    @(negedge clk);
    retain = retain_mode_t'(r);
    restore = v;
    restart = 1'h1;
    @(posedge clk);
    #1;
    check(r & v, 1'h0);
    @(negedge clk);
    restart = 1'h0;
    @(posedge clk);
    #1;
    check(1'h1, 1'h0);
  endtask

  task automatic test_restart;
    restart_case(1'h0, 1'h1);
    restart_case(1'h1, 1'h1);
    restart_case(1'h1, 1'h0);
    $display("test restart done");
  endtask

  // trigger held high across a reset: cleared sample makes a fresh edge
  task automatic test_reset;
    ev(3'h6, 1'h1, 1'h0);
    want = 3'h4;
    @(negedge clk);
    rst = 1'h1;
    @(posedge clk);
    #1;
    check(1'h0, 1'h0);
    @(negedge clk);
    rst = 1'h0;
    @(posedge clk);
    #1;
    check(1'h1, 1'h1);
    $display("test reset done");
  endtask

  // trigger rises while no program cycle runs, seen at the next one
  task automatic test_idle;
    ev(3'h0, 1'h1, 1'h0);
    want = 3'h4;
    @(negedge clk);
    eval = 1'h0;
    @(posedge clk);
    #1;
    check(1'h1, 1'h0);
    @(negedge clk);
    eval = 1'h1;
    @(posedge clk);
    #1;
    check(1'h0, 1'h1);
    $display("test idle done");
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(negedge clk);
    rst = 1'h0;
    eval = 1'h1;
    @(posedge clk);
    #1;
    test_toggle();
    test_forced();
    test_both();
    test_restart();
    test_reset();
    test_idle();
    conclude();
  end

  // a hung run still ends through the closing report
  initial begin
    #100000;
    err_count++;
    conclude();
  end
endmodule // toggle_relay_set_reset_tb_top

/* File: rtl/toggle_relay_consts.svh */
`ifndef TOGGLE_RELAY_CONSTS_SVH
`define TOGGLE_RELAY_CONSTS_SVH

// reset values (relay output also after a non-retentive restart) and the set and clear levels
`define RELAY_OUT_RESET    1'h0
`define TRIG_SAMPLE_RESET  1'h0
`define RELAY_SET_LEVEL    1'h1
`define RELAY_CLEAR_LEVEL  1'h0

`endif

/* File: rtl/toggle_relay_pkg.sv */
package toggle_relay_pkg;

  // which input wins while set and clear are both active
  typedef enum logic [0:0] {
    clear_priority_mode = 1'b0,
    set_priority_mode   = 1'b1
  } priority_mode_t;

  // whether the relay state survives a power loss
  typedef enum logic [0:0] {
    retain_off = 1'b0,
    retain_on  = 1'b1
  } retain_mode_t;

  typedef struct packed {
    logic last_trig;
  } edge_state_t;

  typedef struct packed {
    logic relay;
    logic rise_seen;
  } relay_state_t;

endpackage

/* File: rtl/toggle_relay_set_reset.sv */
`timescale 1ns/1ps
`include "toggle_relay_consts.svh"

module toggle_relay_set_reset (
  // clock and reset
  input  wire logic                            sys_clk_in,
  input  wire logic                            reset_in,
  // program cycle and restart
  input  wire logic                            eval_in,
  input  wire logic                            restart_in,
  input  wire logic                            restore_value_in,
  // configuration
  input  wire toggle_relay_pkg::priority_mode_t priority_mode_in,
  input  wire toggle_relay_pkg::retain_mode_t   retain_mode_in,
  // function inputs
  input  wire logic                            trig_in,
  input  wire logic                            set_in,
  input  wire logic                            clear_in,
  // outputs
  output logic                                 relay_out,
  output logic                                 saved_value_out,
  output logic                                 toggled_out
);
  import toggle_relay_pkg::*;

  relay_state_t st;
  relay_state_t next_st;
  logic         rise;
  logic         last_trig;
  logic         any_force;

  ////////////////////////////////////////////////////////////////////////
  // trigger edge detection

  trigger_edge_detect u_edge (
    .sys_clk_in    (sys_clk_in),
    .reset_in      (reset_in),
    .eval_in       (eval_in),
    .trig_in       (trig_in),
    .rise_out      (rise),
    .last_trig_out (last_trig)
  );

  assign any_force = set_in | clear_in;

  ////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    next_st           = st;
    next_st.rise_seen = 1'h0;
    if (restart_in) begin
      // restart takes the whole cycle; no relay evaluation in it, but eval_in still updates the trigger sample
      case (retain_mode_in)
        retain_on: begin
          next_st.relay = restore_value_in;
        end
        retain_off: begin
          next_st.relay = `RELAY_OUT_RESET;
        end
        default: begin
          next_st.relay = `RELAY_OUT_RESET;
        end
      endcase
    end else if (eval_in) begin
      if (set_in && clear_in) begin
        case (priority_mode_in)
          set_priority_mode: begin
            next_st.relay = `RELAY_SET_LEVEL;
          end
          clear_priority_mode: begin
            next_st.relay = `RELAY_CLEAR_LEVEL;
          end
          default: begin
            next_st.relay = `RELAY_CLEAR_LEVEL;
          end
        endcase
      end else if (set_in) begin
        next_st.relay = `RELAY_SET_LEVEL;
      end else if (clear_in) begin
        next_st.relay = `RELAY_CLEAR_LEVEL;
      end else if (rise) begin
        // forcing inputs are checked first so the edge is lost
        next_st.relay     = ~st.relay;
        next_st.rise_seen = 1'h1;
      end
    end
    if (reset_in) begin
      next_st.relay     = `RELAY_OUT_RESET;
      next_st.rise_seen = 1'h0;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    st <= next_st;
  end

  // the saved copy is what nonvolatile storage should capture
  assign relay_out       = st.relay;
  assign saved_value_out = st.relay;
  assign toggled_out     = st.rise_seen;

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge sys_clk_in);
  endclocking

  default disable iff (reset_in);

  toggle_on_edge_a: assert property (
    eval_in && !restart_in && !any_force && trig_in && !last_trig
    |=> relay_out != $past(relay_out) && toggled_out)
    else $error("trigger edge did not invert the output");

  hold_no_eval_a: assert property (
    !eval_in && !restart_in |=> $stable(relay_out))
    else $error("output changed outside a program cycle");

  hold_no_edge_a: assert property (
    eval_in && !restart_in && !any_force && !(trig_in && !last_trig)
    |=> $stable(relay_out))
    else $error("output changed without a trigger edge");

  trig_ignored_a: assert property (
    eval_in && !restart_in && any_force
    |=> !toggled_out && relay_out == ($past(set_in) &&
        (!$past(clear_in) ||
         $past(priority_mode_in) == set_priority_mode)))
    else $error("trigger acted while set or clear was active");

  set_drives_a: assert property (
    eval_in && !restart_in && set_in && !clear_in |=> relay_out)
    else $error("set did not drive the output high");

  clear_drives_a: assert property (
    eval_in && !restart_in && clear_in && !set_in |=> !relay_out)
    else $error("clear did not drive the output low");

  both_set_prio_a: assert property (
    eval_in && !restart_in && set_in && clear_in &&
    priority_mode_in == set_priority_mode |=> relay_out)
    else $error("set priority not honoured");

  both_clear_prio_a: assert property (
    eval_in && !restart_in && set_in && clear_in &&
    priority_mode_in == clear_priority_mode |=> !relay_out)
    else $error("clear priority not honoured");

  restart_clear_a: assert property (
    restart_in && retain_mode_in == retain_off |=> !relay_out)
    else $error("non-retentive restart left the output set");

  restart_keep_a: assert property (
    restart_in && retain_mode_in == retain_on
    |=> relay_out == $past(restore_value_in))
    else $error("retentive restart lost the saved value");

  single_toggle_a: assert property (
    toggled_out && eval_in && trig_in |=> !toggled_out)
    else $error("held trigger toggled twice");

  toggle_pulse_a: assert property (
    toggled_out |=> !toggled_out)
    else $error("toggle pulse lasted more than one cycle");

  toggle_cause_a: assert property (
    toggled_out |-> $past(eval_in) && !$past(restart_in) &&
    !$past(set_in) && !$past(clear_in) && $past(trig_in))
    else $error("toggle reported without a free trigger edge");

  toggle_flips_a: assert property (
    toggled_out |-> relay_out != $past(relay_out))
    else $error("toggle reported but the output kept its level");

  change_cause_a: assert property (
    relay_out != $past(relay_out)
    |-> $past(eval_in) || $past(restart_in) || $past(reset_in))
    else $error("output changed with no program cycle");

  no_eval_quiet_a: assert property (
    !eval_in && !restart_in |=> !toggled_out)
    else $error("toggle reported outside a program cycle");

  set_beats_edge_a: assert property (
    eval_in && !restart_in && set_in && !clear_in && trig_in &&
    !last_trig |=> relay_out && !toggled_out)
    else $error("trigger edge overrode an active set");

  clear_beats_edge_a: assert property (
    eval_in && !restart_in && clear_in && !set_in && trig_in &&
    !last_trig |=> !relay_out && !toggled_out)
    else $error("trigger edge overrode an active clear");

  both_edge_ignored_a: assert property (
    eval_in && !restart_in && set_in && clear_in && trig_in &&
    !last_trig |=> !toggled_out)
    else $error("trigger edge acted while set and clear were active");

  restart_no_toggle_a: assert property (
    restart_in |=> !toggled_out)
    else $error("restart cycle reported a toggle");

  restart_beats_set_a: assert property (
    restart_in && retain_mode_in == retain_off && eval_in && set_in
    |=> !relay_out)
    else $error("set acted during a non-retentive restart");

  retain_restore_a: assert property (
    restart_in && retain_mode_in == retain_on && !restore_value_in
    |=> !relay_out && !toggled_out)
    else $error("retentive restart did not return a saved low");

  reset_state_a: assert property (@(posedge sys_clk_in) disable iff (1'b0)
    reset_in |=> !relay_out && !toggled_out)
    else $error("reset did not clear the output");

endmodule // toggle_relay_set_reset

/* File: rtl/trigger_edge_detect.sv */
`timescale 1ns/1ps
`include "toggle_relay_consts.svh"

module trigger_edge_detect (
  // clock and reset
  input  wire logic sys_clk_in,
  input  wire logic reset_in,
  // program cycle and trigger
  input  wire logic eval_in,
  input  wire logic trig_in,
  // detected edge
  output logic      rise_out,
  output logic      last_trig_out
);
  import toggle_relay_pkg::*;

  edge_state_t st;
  edge_state_t next_st;

  ////////////////////////////////////////////////////////////////////////
  // sample once per program cycle; compare against the previous sample
  always_comb begin
    next_st = st;
    if (eval_in) begin
      next_st.last_trig = trig_in;
    end
    if (reset_in) begin
      next_st.last_trig = `TRIG_SAMPLE_RESET;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    st <= next_st;
  end

  // combinational so the output can react in the same program cycle
  assign rise_out      = eval_in & trig_in & ~st.last_trig;
  assign last_trig_out = st.last_trig;

  edge_only_a: assert property (@(posedge sys_clk_in)
    disable iff (reset_in) rise_out |=> last_trig_out)
    else $error("edge flagged but the high sample was not kept");

  sample_hold_a: assert property (@(posedge sys_clk_in)
    disable iff (reset_in) !eval_in |=> $stable(last_trig_out))
    else $error("trigger sample moved outside a program cycle");

endmodule // trigger_edge_detect
